/* File: include/sfc_cfg.svh */
/*
  Constants for the serial flash control front end: status bit positions, reset values,
  instruction codes and timing counts.
  Assumes inclusion by bare name from the timer and control core modules.
*/
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// status register layout
`define SFC_STATUS_W        8
`define SFC_BIT_BUSY        0
`define SFC_BIT_WEL         1
`define SFC_BIT_BP_LO       2
`define SFC_BIT_BP_HI       4
`define SFC_BIT_RSV         5
`define SFC_BIT_AAI         6
`define SFC_BIT_LOCK        7

// power-up values
`define SFC_STATUS_RESET    8'h1C
`define SFC_BP_RESET        3'h7
`define SFC_LOCK_RESET      1'b0

// instruction codes
`define SFC_OP_READ_STATUS  8'h05
`define SFC_OP_WRITE_ENABLE_CMD         8'h06
`define SFC_OP_WRITE_DISABLE_CMD         8'h04
`define SFC_OP_STATUS_WRITE_CMD         8'h01
`define SFC_OP_BYTE_PROG    8'h02
`define SFC_OP_AUTO_INC     8'hAD
`define SFC_OP_SECTOR_ERASE 8'h20
`define SFC_OP_BLOCK_ERASE  8'h52
`define SFC_OP_CHIP_ERASE   8'h60
`define SFC_OP_PAUSE_SELECT 8'hA7

// frame lengths in whole bytes
`define SFC_LEN_STATUS_WRITE_CMD        3'h2
`define SFC_LEN_PROG        3'h5
`define SFC_LEN_AUTO_INC    3'h2
`define SFC_LEN_ERASE       3'h4

// timing
`define SFC_CLK_PERIOD_NS   10
`define SFC_RST_MIN_NS      100
`define SFC_RST_MIN_CYC     ((`SFC_RST_MIN_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`define SFC_PROG_CYC_DEF    500
`define SFC_ERASE_CYC_DEF   2000
`define SFC_CHIP_CYC_DEF    4000

`endif

/* File: include/sfc_pkg.sv */
/*
  Types shared by the serial flash control front end: status word, frame capture and
  internal operation kinds.
  Assumes the constants header sits on the include path.
*/
package sfc_pkg;

    typedef struct packed {
        logic       protectLock;
        logic       autoIncrementProgram;
        logic       reservedBit;
        logic [2:0] protectLevel;
        logic       writeEnableLatch;
        logic       busy;
    } sfc_status_s;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] data;
        logic [2:0] byteCnt;
        logic [2:0] bitCnt;
        logic [7:0] shift;
    } sfc_frame_s;

    typedef enum logic [1:0] {
        SFC_OP_IDLE  = 2'b00,
        SFC_OP_PROG  = 2'b01,
        SFC_OP_ERASE = 2'b10,
        SFC_OP_CHIP  = 2'b11
    } sfc_op_e;

endpackage

/* File: core/sfc_sync.sv */
/*
  Two-flop level synchroniser, any width, with a reset value per bit.
  Assumes each bit is a slow level or is only read while quasi-static.
*/
module sfc_sync #(
    parameter int unsigned         W       = 1,
    parameter logic [W-1:0]        RST_VAL = '0
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [W-1:0]      d,
    output logic [W-1:0]           q
);
    import sfc_pkg::*;

    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sfc_sync

/* File: core/sfc_op_timer.sv */
/*
  Internal program/erase timer: holds busy for a set number of system clocks per kind.
  Assumes a one-cycle start pulse while idle and an abort level from device reset.
*/
`include "sfc_cfg.svh"
module sfc_op_timer #(
    parameter int unsigned         PROG_CYC  = `SFC_PROG_CYC_DEF,
    parameter int unsigned         ERASE_CYC = `SFC_ERASE_CYC_DEF,
    parameter int unsigned         CHIP_CYC  = `SFC_CHIP_CYC_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              start,
    input  wire sfc_pkg::sfc_op_e  kind,
    input  wire logic              abort,
    output logic                   busy,
    output logic                   done
);
    import sfc_pkg::*;

    logic [31:0] count_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 32'h0000_0000;
        end else if (abort) begin
            count_r <= 32'h0000_0000;
        end else if (start && !busy) begin
            case (kind)
                SFC_OP_PROG:  count_r <= 32'(PROG_CYC);
                SFC_OP_ERASE: count_r <= 32'(ERASE_CYC);
                SFC_OP_CHIP:  count_r <= 32'(CHIP_CYC);
                default:      count_r <= 32'h0000_0000;
            endcase
        end else if (count_r != 32'h0000_0000) begin
            count_r <= count_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= busy && !abort && (count_r == 32'h0000_0001);
            if (abort) begin
                busy <= 1'b0;
            end else if (start && !busy) begin
                busy <= (kind != SFC_OP_IDLE);
            end else if (count_r == 32'h0000_0001) begin
                busy <= 1'b0;
            end
        end
    end
endmodule // sfc_op_timer

/* File: core/sfc_ctrl.sv */
/*
  Serial flash control front end: serial link on the link clock (bit capture, instruction
  framing, status shift-out) and on the system clock the status register, shared reset/pause
  pin, write protection and the internal operation timer.
  Assumes the host drives the link clock, select, serial input and the shared and protect pins;
  the output wire is resolved outside from soOut and soOe.
*/
`include "sfc_cfg.svh"
// How it works
// - modes 0 and 3 both accepted
// - capture on rising edge, drive after falling
// - shared pin resets until pause-select instruction
// - pause function sticks until power cycle
// - reset pin low 100 ns, output floats
// - completed reset restores status defaults
// - reset aborts operation, ends auto-increment, floats output
// - pause freezes bit position, transfer resumes
// - pause entry only while clock low
// - pause exit only while clock low
// - paused: output floats, clock and input ignored
// - deselect during pause drops the frame
// - status write refused when protect low, lock set
// - bit 0 busy, read-only, resets 0
// - bit 1 write latch; zero refuses writes
// - write latch auto-clears on listed completions
// - bits 2..4 protect level, default ones
// - bit 6 auto-increment flag, bit 5 zero
// - bit 7 lock makes protect bits read-only while protect low
// - deselect mid-byte abandons the instruction
// - bytes shifted most significant bit first
// - protect low with lock freezes lock, levels
module sfc_ctrl #(
    parameter logic [7:0]          OP_PAUSE_SELECT = `SFC_OP_PAUSE_SELECT,
    parameter int unsigned         PROG_CYC        = `SFC_PROG_CYC_DEF,
    parameter int unsigned         ERASE_CYC       = `SFC_ERASE_CYC_DEF,
    parameter int unsigned         CHIP_CYC        = `SFC_CHIP_CYC_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              sckClk,
    input  wire logic              csPin_n,
    input  wire logic              siPin,
    input  wire logic              rstHoldPin_n,
    input  wire logic              wpPin_n,
    output logic                   soOut,
    output logic                   soOe,
    output sfc_pkg::sfc_status_s   statusView,
    output logic                   pauseSelected,
    output logic                   pauseActive
);
    import sfc_pkg::*;

    localparam logic [7:0] RST_CYC = 8'(`SFC_RST_MIN_CYC);

    // link domain
    sfc_frame_s   frame_r;
    logic         newFrame_r;
    logic         readMode_r;
    logic         soBit_r;
    logic         frameClr_n;
    logic         linkPaused;
    logic [7:0]   rxByte;
    logic [8:0]   linkSync;
    logic         pauseSelLink;
    logic [7:0]   statLink;

    // system domain
    logic [4:0]   pinSync;
    logic         csS;
    logic         holdPinS;
    logic         wpS;
    logic         sckS;
    logic         readModeS;
    logic         csPrev_r;
    logic         csRise;
    logic [7:0]   rstCnt_r;
    logic         pinResetLow;
    logic         resetting;
    logic         pauseSel_r;
    logic         pauseActive_r;
    logic         soOe_r;
    logic         wel_r;
    logic         aai_r;
    logic         lock_r;
    logic [2:0]   bp_r;
    sfc_status_s  statusView_r;
    logic         opBusy;
    logic         opDone;
    logic         frameOk;
    logic         exec;
    logic         isWren;
    logic         isWrdi;
    logic         srDone;
    logic         srWrite;
    logic         progStart;
    logic         aaiStart;
    logic         eraseStart;
    logic         chipStart;
    logic         opStart;
    sfc_op_e      opKind;

    // ---- link clock domain ----

    assign frameClr_n = rst_n & ~csPin_n;
    // the shared pin is driven by the host alongside the link clock, so it is read here unsynchronised
    assign linkPaused = pauseSelLink & ~rstHoldPin_n;
    assign rxByte     = {frame_r.shift[6:0], siPin};

    sfc_sync #(
        .W       (9),
        .RST_VAL ({1'b0, `SFC_STATUS_RESET})
    ) uLinkSync (
        .clk     (sckClk),
        .rst_n   (rst_n),
        .d       ({pauseSel_r, statusView_r}),
        .q       (linkSync)
    );

    assign pauseSelLink = linkSync[8];
    assign statLink     = linkSync[7:0];

    // select high arms a fresh frame; no edge is needed, so mode 3 idle high is fine
    always_ff @(posedge sckClk or negedge frameClr_n) begin
        if (!frameClr_n) begin
            newFrame_r <= 1'b1;
        end else if (!linkPaused) begin
            newFrame_r <= 1'b0;
        end
    end

    // frame capture survives deselect so the system side can judge it after select rises
    always_ff @(posedge sckClk or negedge rst_n) begin
        if (!rst_n) begin
            frame_r <= '0;
        end else if (!linkPaused) begin
            if (newFrame_r) begin
                frame_r.shift   <= {7'h00, siPin};
                frame_r.bitCnt  <= 3'h1;
                frame_r.byteCnt <= 3'h0;
            end else begin
                frame_r.shift  <= rxByte;
                frame_r.bitCnt <= frame_r.bitCnt + 3'h1;
                if (frame_r.bitCnt == 3'h7) begin
                    if (frame_r.byteCnt != 3'h7) begin
                        frame_r.byteCnt <= frame_r.byteCnt + 3'h1;
                    end
                    if (frame_r.byteCnt == 3'h0) begin
                        frame_r.opcode <= rxByte;
                    end
                    if (frame_r.byteCnt == 3'h1) begin
                        frame_r.data <= rxByte;
                    end
                end
            end
        end
    end

    always_ff @(posedge sckClk or negedge frameClr_n) begin
        if (!frameClr_n) begin
            readMode_r <= 1'b0;
        end else if (!linkPaused && !newFrame_r && frame_r.bitCnt == 3'h7 && frame_r.byteCnt == 3'h0
                     && rxByte == `SFC_OP_READ_STATUS) begin
            readMode_r <= 1'b1;
        end
    end

    // status bits leave on the falling edge, most significant first, repeating each byte
    always_ff @(negedge sckClk or negedge rst_n) begin
        if (!rst_n) begin
            soBit_r <= 1'b0;
        end else if (!linkPaused) begin
            soBit_r <= statLink[3'h7 - frame_r.bitCnt];
        end
    end

    assign soOut = soBit_r;

    // ---- system clock domain ----

    // the link clock is sampled here as a plain level only to judge pause entry and exit
    sfc_sync #(
        .W       (5),
        .RST_VAL (5'h1C)
    ) uPinSync (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .d       ({csPin_n, rstHoldPin_n, wpPin_n, sckClk, readMode_r}),
        .q       (pinSync)
    );

    assign csS       = pinSync[4];
    assign holdPinS  = pinSync[3];
    assign wpS       = pinSync[2];
    assign sckS      = pinSync[1];
    assign readModeS = pinSync[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csPrev_r <= 1'b1;
        end else begin
            csPrev_r <= csS;
        end
    end

    assign csRise = csS & ~csPrev_r;

    // shared pin as reset: must stay low long enough before it counts
    assign pinResetLow = ~pauseSel_r & ~holdPinS;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstCnt_r <= 8'h00;
        end else if (!pinResetLow) begin
            rstCnt_r <= 8'h00;
        end else if (rstCnt_r != RST_CYC) begin
            rstCnt_r <= rstCnt_r + 8'h01;
        end
    end

    assign resetting = pinResetLow & (rstCnt_r == RST_CYC);

    // pause follows the pin only while the clock level is low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pauseActive_r <= 1'b0;
        end else if (csS || !pauseSel_r) begin
            pauseActive_r <= 1'b0;
        end else if (!sckS) begin
            pauseActive_r <= ~holdPinS;
        end
    end

    // frame judged once select rises; link registers are still by then
    assign frameOk = csRise & ~pauseActive_r & ~pinResetLow
                     & (frame_r.bitCnt == 3'h0) & (frame_r.byteCnt != 3'h0);
    // while busy only status reads are honoured; others are dropped
    assign exec    = frameOk & ~opBusy;

    assign isWren     = exec && frame_r.opcode == `SFC_OP_WRITE_ENABLE_CMD;
    assign isWrdi     = exec && frame_r.opcode == `SFC_OP_WRITE_DISABLE_CMD;
    assign srDone     = exec && frame_r.opcode == `SFC_OP_STATUS_WRITE_CMD && frame_r.byteCnt >= `SFC_LEN_STATUS_WRITE_CMD;
    assign srWrite    = srDone && wel_r && (wpS || !lock_r);
    assign progStart  = exec && wel_r && frame_r.opcode == `SFC_OP_BYTE_PROG
                        && frame_r.byteCnt >= `SFC_LEN_PROG;
    assign aaiStart   = exec && wel_r && frame_r.opcode == `SFC_OP_AUTO_INC
                        && frame_r.byteCnt >= `SFC_LEN_AUTO_INC;
    assign eraseStart = exec && wel_r && frame_r.byteCnt >= `SFC_LEN_ERASE
                        && (frame_r.opcode == `SFC_OP_SECTOR_ERASE || frame_r.opcode == `SFC_OP_BLOCK_ERASE);
    // whole-array erase only with every protect level bit clear
    assign chipStart  = exec && wel_r && frame_r.opcode == `SFC_OP_CHIP_ERASE && bp_r == 3'h0;
    assign opStart    = progStart | aaiStart | eraseStart | chipStart;

    always_comb begin
        opKind = SFC_OP_IDLE;
        if (progStart || aaiStart) begin
            opKind = SFC_OP_PROG;
        end else if (eraseStart) begin
            opKind = SFC_OP_ERASE;
        end else if (chipStart) begin
            opKind = SFC_OP_CHIP;
        end
    end

    sfc_op_timer #(
        .PROG_CYC  (PROG_CYC),
        .ERASE_CYC (ERASE_CYC),
        .CHIP_CYC  (CHIP_CYC)
    ) uOpTimer (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .start     (opStart),
        .kind      (opKind),
        .abort     (resetting),
        .busy      (opBusy),
        .done      (opDone)
    );

    // sticky pause function; nothing but power-on clears it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pauseSel_r <= 1'b0;
        end else if (exec && frame_r.opcode == OP_PAUSE_SELECT) begin
            pauseSel_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wel_r <= 1'b0;
        end else if (resetting) begin
            wel_r <= 1'b0;
        end else if (isWren) begin
            wel_r <= 1'b1;
        end else if (isWrdi || srDone) begin
            wel_r <= 1'b0;
        end else if (opDone && !aai_r) begin
            wel_r <= 1'b0;
        end
    end

    // auto-increment stays armed across bytes until disabled or reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aai_r <= 1'b0;
        end else if (resetting || isWrdi) begin
            aai_r <= 1'b0;
        end else if (aaiStart) begin
            aai_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_r   <= `SFC_BP_RESET;
            lock_r <= `SFC_LOCK_RESET;
        end else if (resetting) begin
            bp_r   <= `SFC_BP_RESET;
            lock_r <= `SFC_LOCK_RESET;
        end else if (srWrite) begin
            bp_r   <= frame_r.data[`SFC_BIT_BP_HI:`SFC_BIT_BP_LO];
            lock_r <= frame_r.data[`SFC_BIT_LOCK];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statusView_r <= `SFC_STATUS_RESET;
        end else begin
            statusView_r.protectLock          <= lock_r;
            statusView_r.autoIncrementProgram <= aai_r;
            statusView_r.reservedBit          <= 1'b0;
            statusView_r.protectLevel         <= bp_r;
            statusView_r.writeEnableLatch     <= wel_r;
            statusView_r.busy                 <= opBusy;
        end
    end

    // output floats in reset, in pause and outside a status read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            soOe_r <= 1'b0;
        end else begin
            soOe_r <= ~csS & readModeS & ~pauseActive_r & ~pinResetLow;
        end
    end

    assign soOe          = soOe_r;
    assign statusView    = statusView_r;
    assign pauseSelected = pauseSel_r;
    assign pauseActive   = pauseActive_r;
endmodule // sfc_ctrl

/* File: bench/sfc_ctrl_chk.sv */
/*
  Port checker for the serial flash control front end: status word, pin reset, pause.
  Assumes binding to sfc_ctrl; everything is judged on sys_clk.
*/
module sfc_ctrl_chk (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 sckClk,
    input wire logic                 rstHoldPin_n,
    input wire logic                 wpPin_n,
    input wire logic                 soOut,
    input wire logic                 soOe,
    input wire sfc_pkg::sfc_status_s statusView,
    input wire logic                 pauseSelected,
    input wire logic                 pauseActive
);
    timeunit 1ns;
    timeprecision 100ps;
    import sfc_pkg::*;
    logic [4:0] lowCnt_r;
    // saturates so a long pin reset stays legal
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_r <= '0;
        end else if (rstHoldPin_n || pauseSelected) begin
            lowCnt_r <= '0;
        end else if (lowCnt_r != 5'h1F) begin
            lowCnt_r <= lowCnt_r + 5'h01;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RST_VAL: assert property ($rose(rst_n) |-> statusView == 8'h1C)
        else $error("status not at power-up value");
    AST_RSV_ZERO: assert property (statusView.reservedBit == 1'b0)
        else $error("reserved status bit set");
    AST_SEL_STICKY: assert property ($past(pauseSelected) |-> pauseSelected)
        else $error("pause selection lost");
    AST_PAUSE_SEL: assert property (pauseActive |-> pauseSelected)
        else $error("paused without pause selection");
    AST_PAUSE_FLOAT: assert property (pauseActive |-> ##[0:3] !soOe)
        else $error("output driven while paused");
    AST_PIN_FLOAT: assert property (lowCnt_r >= 5'h05 |-> !soOe)
        else $error("output driven during pin reset");
    AST_PIN_STATUS: assert property (lowCnt_r >= 5'h10 |-> statusView == 8'h1C)
        else $error("pin reset left status changed");
    AST_WEL_DONE: assert property ($fell(statusView.busy) && !statusView.autoIncrementProgram
        |-> ##[0:2] !statusView.writeEnableLatch)
        else $error("write latch kept after operation");
    AST_BUSY_WEL: assert property ($rose(statusView.busy) |-> $past(statusView.writeEnableLatch))
        else $error("operation started without write latch");
    AST_LOCK_HOLD: assert property ((!wpPin_n && statusView.protectLock && (rstHoldPin_n || pauseSelected))
        |=> $stable({statusView.protectLock, statusView.protectLevel}))
        else $error("locked protection bits changed");
    AST_SO_FALL: assert property ($changed(soOut) |-> !sckClk)
        else $error("output changed outside link clock low phase");
    COV_PAUSE: cover property ($rose(pauseActive));
    COV_BUSY: cover property ($fell(statusView.busy));
    COV_PIN_RST: cover property (lowCnt_r == 5'h10);
endmodule // sfc_ctrl_chk

bind sfc_ctrl sfc_ctrl_chk u_chk (.sys_clk, .rst_n, .sckClk, .rstHoldPin_n, .wpPin_n, .soOut, .soOe,
    .statusView, .pauseSelected, .pauseActive);

/* File: bench/sfc_host_model.sv */
/*
  Host link model: link clock, select and serial input in mode 0 or mode 3.
  Assumes the bench calls its tasks; a floating output reads as the inverse of the last bit.
*/
module sfc_host_model (
    output logic      sckClk,
    output logic      csPin_n,
    output logic      siPin,
    input  wire logic soOut,
    input  wire logic soOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       idleHigh = 1'b0;
    int         halfNs   = 15;
    logic [7:0] rxByte   = '0;
    initial begin
        sckClk  = 1'b0;
        csPin_n = 1'b1;
        siPin   = 1'b1;
    end
    // idle level settles before select falls, so a mode change is no clock edge inside a frame
    task automatic open_frame();
        sckClk  = idleHigh;
        #(halfNs);
        csPin_n = 1'b0;
        #(halfNs);
    endtask
    // clock stands high after the last bit so a pause can fall on a high phase
    task automatic shift_bits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sckClk = 1'b0;
            siPin  = v[i];
            #(halfNs);
            sckClk = 1'b1;
            rxByte = {rxByte[6:0], soOe ? soOut : ~rxByte[0]};
            #(halfNs);
        end
    endtask
    task automatic close_frame();
        sckClk  = idleHigh;
        #(halfNs);
        csPin_n = 1'b1;
        siPin   = ~siPin;
        #60;
    endtask
endmodule // sfc_host_model

/* File: bench/sfc_ctrl_tb_top.sv */
/*
  Self-checking bench for sfc_ctrl: status, protection, operations, pin reset, pause.
  Assumes the host model drives the link; shortened operation counts.
*/
module sfc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sfc_pkg::*;
    logic        sys_clk, rst_n, sckClk, csPin_n, siPin, rstHoldPin_n, wpPin_n;
    logic        soOut, soOe, pauseSelected, pauseActive;
    sfc_status_s statusView;
    logic [7:0]  s, busyLen;
    int          nErrors, checkCount, cycles;
    logic [7:0]  ops[4] = '{8'h02, 8'h20, 8'h52, 8'h60};
    int          lens[4] = '{5, 4, 4, 1};
    logic [7:0]  cyc[4] = '{8'hC8, 8'hDC, 8'hDC, 8'hF0};
    sfc_host_model host (.sckClk, .csPin_n, .siPin, .soOut, .soOe);
    sfc_ctrl #(.OP_PAUSE_SELECT(8'hA7), .PROG_CYC(200), .ERASE_CYC(220), .CHIP_CYC(240)) dut (
        .sys_clk, .rst_n, .sckClk, .csPin_n, .siPin, .rstHoldPin_n, .wpPin_n, .soOut, .soOe,
        .statusView, .pauseSelected, .pauseActive);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (statusView.busy === 1'b1) busyLen <= busyLen + 8'h01;
        if (cycles == 20000) begin
            nErrors++;
            results();
        end
    end
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic pins(input logic rh, input logic wp);
        @(posedge sys_clk);
        #1;
        rstHoldPin_n = rh;
        wpPin_n      = wp;
    endtask
    task automatic frame(input logic [7:0] op, input logic [7:0] d, input int nb);
        @(posedge sys_clk);
        #1;
        host.open_frame();
        host.shift_bits(op, 8);
        for (int k = 1; k < nb; k++) host.shift_bits(d, 8);
        host.close_frame();
    endtask
    // the answer crosses late, so the third byte is the one judged
    task automatic read_status();
        frame(8'h05, 8'h00, 3);
        s = host.rxByte;
    endtask
    task automatic t_reset();
        chk8("status", 8'h1C, statusView);
        chk1("oe", 1'b0, soOe);
        read_status();
        chk8("link status", 8'h1C, s);
    endtask
    task automatic t_enable();
        host.idleHigh = 1'b1;
        host.halfNs = 40;
        frame(8'h06, 8'h00, 1);
        read_status();
        chk8("mode3 status", 8'h1E, s);
        host.idleHigh = 1'b0;
        host.halfNs = 15;
        frame(8'h04, 8'h00, 1);
        chk1("wel off", 1'b0, statusView.writeEnableLatch);
        host.open_frame();
        host.shift_bits(8'h06, 8);
        host.shift_bits(8'h00, 7);
        host.close_frame();
        chk1("partial", 1'b0, statusView.writeEnableLatch);
    endtask
    task automatic t_protect();
        frame(8'h01, 8'h00, 2);
        chk8("no latch", 8'h1C, statusView);
        frame(8'h06, 8'h00, 1);
        frame(8'h01, 8'hFF, 2);
        chk8("write all", 8'h9C, statusView);
        pins(1'b1, 1'b0);
        frame(8'h06, 8'h00, 1);
        frame(8'h01, 8'h00, 2);
        chk8("locked", 8'h9C, statusView);
        pins(1'b1, 1'b1);
        frame(8'h06, 8'h00, 1);
        frame(8'h01, 8'h00, 2);
        chk8("unlocked", 8'h00, statusView);
    endtask
    task automatic t_program();
        for (int k = 0; k < 4; k++) begin
            busyLen = '0;
            frame(8'h06, 8'h00, 1);
            frame(ops[k], 8'h00, lens[k]);
            read_status();
            chk1("polled busy", 1'b1, s[0]);
            for (int n = 0; n < 1000 && statusView.busy !== 1'b0; n++) @(posedge sys_clk);
            #1;
            chk8("busy cycles", cyc[k], busyLen);
            chk1("wel done", 1'b0, statusView.writeEnableLatch);
        end
    endtask
    task automatic t_abort();
        frame(8'h06, 8'h00, 1);
        frame(8'hAD, 8'h00, 2);
        chk1("aai", 1'b1, statusView.autoIncrementProgram);
        chk1("aai busy", 1'b1, statusView.busy);
        pins(1'b0, 1'b1);
        repeat (20) @(posedge sys_clk);
        chk8("pin reset", 8'h1C, statusView);
        chk1("pin oe", 1'b0, soOe);
        pins(1'b1, 1'b1);
        #10000;
    endtask
    task automatic t_pause();
        frame(8'hA7, 8'h00, 1);
        chk1("selected", 1'b1, pauseSelected);
        host.open_frame();
        host.shift_bits(8'h06, 4);
        pins(1'b0, 1'b1);
        #60;
        chk1("deferred", 1'b0, pauseActive);
        host.shift_bits(8'hFF, 4);
        chk1("paused", 1'b1, pauseActive);
        chk8("no reset", 8'h1C, statusView);
        host.sckClk = 1'b0;
        #60;
        pins(1'b1, 1'b1);
        #60;
        host.shift_bits(8'h60, 4);
        host.close_frame();
        chk1("resumed", 1'b1, statusView.writeEnableLatch);
        frame(8'h04, 8'h00, 1);
        host.open_frame();
        host.shift_bits(8'h06, 8);
        pins(1'b0, 1'b1);
        #60;
        host.close_frame();
        pins(1'b1, 1'b1);
        chk1("dropped", 1'b0, statusView.writeEnableLatch);
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk1("power cycle", 1'b0, pauseSelected);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        rstHoldPin_n = 1'b1;
        wpPin_n = 1'b1;
        busyLen = '0;
        nErrors = 0;
        checkCount = 0;
        cycles = 0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_enable();
        t_protect();
        t_program();
        t_abort();
        t_pause();
        results();
    end
endmodule // sfc_ctrl_tb_top
